// ### rtl/tps_pin_decode.sv
// decodes one timer pin's settings into the function it performs
// assumes configuration inputs are registered by the caller
`timescale 1ns/1ps
`default_nettype none
module tps_pin_decode #(
  parameter int PIN = 0
) (
  input  wire logic            od_i,
  input  wire logic            dpwm_i,
  input  wire logic            pwm_i,
  input  wire logic [2:0]      io_i,
  input  wire logic [1:0]      edge_i,
  output tps_pkg::tps_fn_t     fn_o
);

  logic cmp_code;

  // codes 001 and 01x select a compare waveform
  assign cmp_code = (io_i == 3'h1) || (io_i[2:1] == 2'h1);

  // earlier branches win; listed combinations never overlap
  always_comb begin
    fn_o = tps_pkg::FN_NONE;
    if (PIN == 0) begin
      if (!od_i && dpwm_i && cmp_code) begin
        fn_o = tps_pkg::FN_CMP;
      end else if (dpwm_i && io_i[2]) begin
        fn_o = tps_pkg::FN_CAP;
      end else if (od_i && !dpwm_i && (edge_i == 2'h1 || edge_i[1])) begin
        fn_o = tps_pkg::FN_TRIG;
      end
    end else begin
      if (PIN == 1 && !od_i && !dpwm_i) begin
        fn_o = tps_pkg::FN_DPWM;
      end else if (!od_i && dpwm_i && pwm_i) begin
        fn_o = tps_pkg::FN_PWM;
      end else if (!od_i && dpwm_i && !pwm_i && cmp_code) begin
        fn_o = tps_pkg::FN_CMP;
      end else if (dpwm_i && !pwm_i && io_i[2]) begin
        fn_o = tps_pkg::FN_CAP;
      end
    end
  end

endmodule
`default_nettype wire

// ### rtl/tps_pkg.sv
// constants, field layout and pin-function encoding for the timer pin-function selector
// assumes a 32-bit classic wishbone register port with byte addresses
package tps_pkg;

  // register byte offsets
  localparam logic [7:0] ADR_OUT_DISABLE = 8'h00;
  localparam logic [7:0] ADR_TIMER_MODE  = 8'h04;
  localparam logic [7:0] ADR_IO_CTRL_AB  = 8'h08;
  localparam logic [7:0] ADR_IO_CTRL_CD  = 8'h0C;
  localparam logic [7:0] ADR_TIMER_CTRL2 = 8'h10;
  localparam logic [7:0] ADR_PIN_STATUS  = 8'h14;

  // timer_mode_reg fields
  localparam int MODE_PWM_B_BIT = 0;
  localparam int MODE_PWM_C_BIT = 1;
  localparam int MODE_PWM_D_BIT = 2;
  localparam int MODE_BUF_A_BIT = 3;
  localparam int MODE_BUF_B_BIT = 4;
  localparam int MODE_DPWM_BIT  = 5;

  // io control fields: three control bits, plus output-select bit 3 for c and d only
  localparam int IO_A_LSB       = 0;
  localparam int IO_B_LSB       = 4;
  localparam int IO_C_LSB       = 0;
  localparam int IO_D_LSB       = 4;
  localparam int IO_OUTSEL_BIT  = 3;

  // reset values
  localparam logic [3:0] RST_OUT_DISABLE = 4'hF;
  localparam logic [5:0] RST_TIMER_MODE  = 6'h20;
  localparam logic [7:0] RST_IO_CTRL_AB  = 8'h00;
  localparam logic [7:0] RST_IO_CTRL_CD  = 8'h88;
  localparam logic [1:0] RST_TIMER_CTRL2 = 2'h0;

  // function a pin currently has
  typedef enum logic [2:0] {
    FN_NONE = 3'h0,
    FN_CMP  = 3'h1,
    FN_CAP  = 3'h2,
    FN_TRIG = 3'h3,
    FN_PWM  = 3'h4,
    FN_DPWM = 3'h5
  } tps_fn_t;

endpackage

// ### rtl/tps_top.sv
// pin-function selection and compare-output routing for four timer pins
// assumes compare-match pulses and pwm waves come from the timer core on clk_i,
// and pin inputs are already synchronous to clk_i
//
// The register addresses and the Wishbone interface to the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module tps_top (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic [3:0]  cmp_match_i,
  input  wire logic [2:0]  pwm_wave_i,
  input  wire logic        dpwm_wave_i,
  input  wire logic [3:0]  pin_in_i,
  output logic      [3:0]  pin_out_o,
  output logic      [3:0]  pin_oe_o,
  output logic      [3:0]  capture_o,
  output logic             ext_trigger_o,
  output logic      [1:0]  buffer_en_o
);

  typedef struct packed {
    logic                          ack;
    logic [31:0]                   rdat;
    logic [3:0]                    od;
    logic [5:0]                    mode;
    logic [7:0]                    ioab;
    logic [7:0]                    iocd;
    logic [1:0]                    ctrl2;
    tps_pkg::tps_fn_t [3:0]        fn;
    logic [3:0]                    wave;
    logic [3:0]                    pout;
    logic [3:0]                    poe;
    logic [3:0]                    cap;
    logic                          trig;
  } tps_state_t;

  tps_state_t             st_r;
  tps_state_t             st_nxt;
  tps_pkg::tps_fn_t [3:0] dec_fn;
  logic [2:0]             io_a;
  logic [2:0]             io_b;
  logic [3:0]             io_c;
  logic [3:0]             io_d;
  logic                   dpwm;
  logic [3:0]             pwm_sel;
  logic [3:0]             pwm_w;
  logic                   reroute_c;
  logic                   reroute_d;
  logic                   req;

  // compare-match action: 00 hold, 01 low, 10 high, 11 toggle
  function automatic logic apply_action(input logic level, input logic [1:0] act);
    logic r;
    r = level;
    case (act)
      2'h1:    r = 1'b0;
      2'h2:    r = 1'b1;
      2'h3:    r = ~level;
      default: r = level;
    endcase
    return r;
  endfunction

  // field views of the configuration registers
  assign io_a      = st_r.ioab[tps_pkg::IO_A_LSB +: 3];
  assign io_b      = st_r.ioab[tps_pkg::IO_B_LSB +: 3];
  assign io_c      = st_r.iocd[tps_pkg::IO_C_LSB +: 4];
  assign io_d      = st_r.iocd[tps_pkg::IO_D_LSB +: 4];
  assign dpwm      = st_r.mode[tps_pkg::MODE_DPWM_BIT];
  assign pwm_sel   = {st_r.mode[tps_pkg::MODE_PWM_D_BIT],
                      st_r.mode[tps_pkg::MODE_PWM_C_BIT],
                      st_r.mode[tps_pkg::MODE_PWM_B_BIT],
                      1'b0};
  assign pwm_w     = {pwm_wave_i, 1'b0};
  // output-select bit at 0 hands channel c/d compares to pins a/b
  assign reroute_c = !io_c[tps_pkg::IO_OUTSEL_BIT];
  assign reroute_d = !io_d[tps_pkg::IO_OUTSEL_BIT];
  assign req       = wb_cyc_i && wb_stb_i && !st_r.ack;

  // one decoder per pin, all fed from registered settings
  for (genvar g = 0; g < 4; g++) begin : g_dec
    logic [2:0] io_g;
    assign io_g = (g == 0) ? io_a : (g == 1) ? io_b : (g == 2) ? io_c[2:0] : io_d[2:0];
    tps_pin_decode #(
      .PIN (g)
    ) u_dec (
      .od_i   (st_r.od[g]),
      .dpwm_i (dpwm),
      .pwm_i  (pwm_sel[g]),
      .io_i   (io_g),
      .edge_i (st_r.ctrl2),
      .fn_o   (dec_fn[g])
    );
  end

  // next-state: bus slave, compare latches and pin multiplexers
  always_comb begin
    logic [3:0] w;
    w      = st_r.wave;
    st_nxt = st_r;

    // ack for one cycle, then drop so a held strobe is not taken twice
    st_nxt.ack  = req;
    st_nxt.rdat = 32'h0;
    if (req && wb_we_i && wb_sel_i[0]) begin
      case (wb_adr_i)
        tps_pkg::ADR_OUT_DISABLE: begin
          st_nxt.od = wb_dat_i[3:0];
        end
        tps_pkg::ADR_TIMER_MODE: begin
          st_nxt.mode = wb_dat_i[5:0];
        end
        tps_pkg::ADR_IO_CTRL_AB: begin
          st_nxt.ioab = {1'b0, wb_dat_i[6:4], 1'b0, wb_dat_i[2:0]};
        end
        tps_pkg::ADR_IO_CTRL_CD: begin
          st_nxt.iocd = wb_dat_i[7:0];
        end
        tps_pkg::ADR_TIMER_CTRL2: begin
          st_nxt.ctrl2 = wb_dat_i[1:0];
        end
        default: begin
          st_nxt.ctrl2 = st_r.ctrl2;
        end
      endcase
    end
    // unmapped addresses read zero but are still acknowledged
    if (req && !wb_we_i) begin
      case (wb_adr_i)
        tps_pkg::ADR_OUT_DISABLE: st_nxt.rdat = {28'h0, st_r.od};
        tps_pkg::ADR_TIMER_MODE:  st_nxt.rdat = {26'h0, st_r.mode};
        tps_pkg::ADR_IO_CTRL_AB:  st_nxt.rdat = {24'h0, st_r.ioab};
        tps_pkg::ADR_IO_CTRL_CD:  st_nxt.rdat = {24'h0, st_r.iocd};
        tps_pkg::ADR_TIMER_CTRL2: st_nxt.rdat = {30'h0, st_r.ctrl2};
        tps_pkg::ADR_PIN_STATUS:  st_nxt.rdat = {20'h0, st_r.fn};
        default:                  st_nxt.rdat = 32'h0;
      endcase
    end

    // pin a latch: match a first, then rerouted match c, so c wins a tie
    if (cmp_match_i[0]) begin
      w[0] = apply_action(w[0], io_a[1:0]);
    end
    if (cmp_match_i[2] && reroute_c) begin
      w[0] = apply_action(w[0], io_c[1:0]);
    end
    // pin b latch: match b, then rerouted match d
    if (cmp_match_i[1]) begin
      w[1] = apply_action(w[1], io_b[1:0]);
    end
    if (cmp_match_i[3] && reroute_d) begin
      w[1] = apply_action(w[1], io_d[1:0]);
    end
    // pins c and d keep their own compare only when not rerouted
    if (cmp_match_i[2] && !reroute_c) begin
      w[2] = apply_action(w[2], io_c[1:0]);
    end
    if (cmp_match_i[3] && !reroute_d) begin
      w[3] = apply_action(w[3], io_d[1:0]);
    end
    st_nxt.wave = w;

    // pin drivers follow the decoded function; none means hands off
    st_nxt.fn   = dec_fn;
    st_nxt.pout = 4'h0;
    st_nxt.poe  = 4'h0;
    st_nxt.cap  = 4'h0;
    st_nxt.trig = 1'b0;
    for (int i = 0; i < 4; i++) begin
      case (dec_fn[i])
        tps_pkg::FN_CMP: begin
          st_nxt.pout[i] = w[i];
          // a rerouted channel leaves its own pin undriven
          st_nxt.poe[i]  = !((i == 2 && reroute_c) || (i == 3 && reroute_d));
        end
        tps_pkg::FN_PWM: begin
          st_nxt.pout[i] = pwm_w[i];
          st_nxt.poe[i]  = 1'b1;
        end
        tps_pkg::FN_DPWM: begin
          st_nxt.pout[i] = dpwm_wave_i;
          st_nxt.poe[i]  = 1'b1;
        end
        tps_pkg::FN_CAP: begin
          st_nxt.cap[i] = pin_in_i[i];
        end
        tps_pkg::FN_TRIG: begin
          st_nxt.trig = pin_in_i[0];
        end
        default: begin
          st_nxt.poe[i] = 1'b0;
        end
      endcase
    end
  end

  // single state register, synchronous reset
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_r       <= '0;
      st_r.od    <= tps_pkg::RST_OUT_DISABLE;
      st_r.mode  <= tps_pkg::RST_TIMER_MODE;
      st_r.ioab  <= tps_pkg::RST_IO_CTRL_AB;
      st_r.iocd  <= tps_pkg::RST_IO_CTRL_CD;
      st_r.ctrl2 <= tps_pkg::RST_TIMER_CTRL2;
    end else begin
      st_r <= st_nxt;
    end
  end

  // outputs straight from the state register
  assign wb_dat_o      = st_r.rdat;
  assign wb_ack_o      = st_r.ack;
  assign pin_out_o     = st_r.pout;
  assign pin_oe_o      = st_r.poe;
  assign capture_o     = st_r.cap;
  assign ext_trigger_o = st_r.trig;
  // buffer mode is left to the timer core; rerouting expects it off
  assign buffer_en_o   = {st_r.mode[tps_pkg::MODE_BUF_B_BIT], st_r.mode[tps_pkg::MODE_BUF_A_BIT]};

  // checks on the registered pin and bus behaviour
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  AST_A_CMP_OUT: assert property (
    (!st_r.od[0] && dpwm && io_a == 3'h2)
    |=> (st_r.fn[0] == tps_pkg::FN_CMP && pin_oe_o[0] && pin_out_o[0] == st_r.wave[0]))
    else $error("pin a not driving compare wave");

  AST_B_CAPTURE: assert property (
    (dpwm && !pwm_sel[1] && io_b[2])
    |=> (st_r.fn[1] == tps_pkg::FN_CAP && !pin_oe_o[1] && capture_o[1] == $past(pin_in_i[1])))
    else $error("pin b not capturing");

  AST_A_TRIGGER: assert property (
    (st_r.od[0] && !dpwm && st_r.ctrl2 == 2'h1)
    |=> (ext_trigger_o == $past(pin_in_i[0]) && !pin_oe_o[0]))
    else $error("pin a trigger not passed");

  AST_B_DPWM_OUT: assert property (
    (!st_r.od[1] && !dpwm)
    |=> (pin_oe_o[1] && pin_out_o[1] == $past(dpwm_wave_i)))
    else $error("pin b not driving dual pwm wave");

  AST_D_PWM_OUT: assert property (
    (!st_r.od[3] && dpwm && pwm_sel[3])
    |=> (pin_oe_o[3] && pin_out_o[3] == $past(pwm_wave_i[2])))
    else $error("pin d not driving pwm wave");

  AST_C_STEERED: assert property (
    (reroute_c && dec_fn[2] == tps_pkg::FN_CMP) |=> !pin_oe_o[2])
    else $error("rerouted pin c still driven");

  AST_A_MIX_C: assert property (
    (reroute_c && cmp_match_i[2] && io_c[1:0] == 2'h2 && dec_fn[0] == tps_pkg::FN_CMP)
    |=> (pin_out_o[0] == 1'b1))
    else $error("match c not seen on pin a");

  AST_B_MIX_D: assert property (
    (reroute_d && cmp_match_i[3] && !cmp_match_i[1] && io_d[1:0] == 2'h1)
    |=> (st_r.wave[1] == 1'b0 && st_r.wave[3] == $past(st_r.wave[3])))
    else $error("match d not steered to pin b");

  AST_NO_DRIVE: assert property (
    (st_r.fn[1] == tps_pkg::FN_NONE || st_r.fn[1] == tps_pkg::FN_CAP) |-> !pin_oe_o[1])
    else $error("pin b driven without output function");

  AST_ACK_PULSE: assert property (
    wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");

  // a fresh request is always answered on the very next edge
  AST_ACK_ANSWER: assert property (
    (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o)
    else $error("request not acknowledged");

  // read data only stands while ack does
  AST_RDAT_IDLE: assert property (
    !wb_ack_o |-> (wb_dat_o == 32'h0))
    else $error("read data outside ack");

  AST_C_DIRECT_OUT: assert property (
    (!reroute_c && dec_fn[2] == tps_pkg::FN_CMP)
    |=> (pin_oe_o[2] && pin_out_o[2] == st_r.wave[2]))
    else $error("pin c not driving its own compare wave");

  AST_C_FROZEN: assert property (
    (reroute_c && cmp_match_i[2]) |=> (st_r.wave[2] == $past(st_r.wave[2])))
    else $error("rerouted match c changed pin c latch");

  AST_B_PWM_OUT: assert property (
    (!st_r.od[1] && dpwm && pwm_sel[1])
    |=> (pin_oe_o[1] && pin_out_o[1] == $past(pwm_wave_i[0])))
    else $error("pin b not driving pwm wave");

  AST_C_PWM_OUT: assert property (
    (!st_r.od[2] && dpwm && pwm_sel[2])
    |=> (pin_oe_o[2] && pin_out_o[2] == $past(pwm_wave_i[1])))
    else $error("pin c not driving pwm wave");

  // pin a only ever drives as a compare output
  AST_A_NO_DRIVE: assert property (
    (st_r.fn[0] != tps_pkg::FN_CMP) |-> !pin_oe_o[0])
    else $error("pin a driven without output function");

endmodule
`default_nettype wire

// ### sim/test_tps_pin_function_select.sv
// self-checking bench for tps_top: settings over wishbone, pins via partner
// assumes tps_pin_partner models the external pin circuitry
`timescale 1ns/1ps
`default_nettype none
module test_timer_pin_function_select;
  logic             clk_i = 1'b0;
  logic             rst_i = 1'b1;
  logic             cyc = 1'b0;
  logic             we = 1'b0;
  logic [7:0]       adr = 8'h00;
  logic [31:0]      wdat = 32'h0;
  logic [3:0]       cmp = 4'h0;
  logic [2:0]       pwm = 3'h0;
  logic             dpw = 1'b0;
  logic [31:0]      rdat;
  logic             ack;
  logic [3:0]       pin_in;
  logic [3:0]       pin_out;
  logic [3:0]       pin_oe;
  logic [3:0]       cap;
  logic             trig;
  logic [1:0]       bufe;
  logic [31:0]      rd;
  logic [31:0]      cfg;
  logic [5:0]       md;
  logic [15:0]      cat;
  logic [3:0]       od;
  logic [1:0]       eg;
  logic [3:0]       ps;
  logic             oe_e;
  tps_pkg::tps_fn_t fe [4];
  int               mismatches = 0;
  int               n_compared = 0;
  int               cycles = 0;
  logic [31:0]      rst_tab [7] = '{32'hF, 32'h20, 32'h0, 32'h88, 32'h0, 32'h0, 32'h0};
  logic [31:0]      corner [4] = '{32'h0448400, 32'h8000001, 32'h0000A70, 32'h111120F};
  logic [3:0]       rr_m [6] = '{4'h4, 4'h1, 4'h2, 4'h8, 4'h4, 4'h6};
  logic [1:0]       rr_e [6] = '{2'h1, 2'h0, 2'h2, 2'h0, 2'h1, 2'h3};

  tps_top dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .cmp_match_i(cmp), .pwm_wave_i(pwm), .dpwm_wave_i(dpw), .pin_in_i(pin_in),
    .pin_out_o(pin_out), .pin_oe_o(pin_oe), .capture_o(cap), .ext_trigger_o(trig),
    .buffer_en_o(bufe));
  tps_pin_partner partner (.clk_i(clk_i), .pin_out_i(pin_out), .pin_oe_i(pin_oe), .pin_in_o(pin_in));

  // 200 MHz clock
  always #2.5 clk_i = ~clk_i;

  task automatic tally_and_finish;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // hang guard, far above the roughly 1300 cycles the run needs
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      tally_and_finish();
    end
  end

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      mismatches++;
      $display("mismatch %s exp %h got %h", nm, e, g);
    end
  endtask

  // one classic cycle; holds everything until ack is sampled high
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do @(posedge clk_i); while (ack !== 1'b1);
    rd = rdat;
    cyc <= 1'b0;
  endtask

  function automatic tps_pkg::tps_fn_t fn_exp(input logic o, input logic d, input logic p,
                                              input logic [2:0] io, input logic [1:0] e, input int i);
    if (i == 0 && o && !d && e != 2'h0) return tps_pkg::FN_TRIG;
    if (i == 1 && !o && !d) return tps_pkg::FN_DPWM;
    if (i != 0 && !o && d && p) return tps_pkg::FN_PWM;
    if (d && !p && io[2]) return tps_pkg::FN_CAP;
    if (!o && d && !p && (io == 3'h1 || io[2:1] == 2'h1)) return tps_pkg::FN_CMP;
    return tps_pkg::FN_NONE;
  endfunction

  initial begin
    void'($urandom(32'h1f1c));
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    // reset values, read-only status and an unmapped place
    wb(1'b1, 8'h14, 32'hFFF);
    wb(1'b1, 8'h18, 32'hFF);
    for (int k = 0; k < 7; k++) begin
      wb(1'b0, 8'(4 * k), 32'h0);
      chk("reset read", rst_tab[k], rd);
    end
    $display("test reset done");
    // corner then random settings, status and pin levels against the tables
    for (int n = 0; n < 60; n++) begin
      cfg = (n < 4) ? corner[n] : $urandom;
      od = cfg[3:0];
      md = cfg[9:4];
      cat = cfg[25:10];
      eg = cfg[27:26];
      wb(1'b1, 8'h00, {28'h0, od});
      wb(1'b1, 8'h04, {26'h0, md});
      wb(1'b1, 8'h08, {24'h0, cat[7:0]});
      wb(1'b1, 8'h0C, {24'h0, cat[15:8]});
      wb(1'b1, 8'h10, {30'h0, eg});
      for (int i = 0; i < 4; i++) begin
        fe[i] = fn_exp(od[i], md[5], (i == 0) ? 1'b0 : md[i - 1], cat[4 * i +: 3], eg, i);
      end
      wb(1'b0, 8'h14, 32'h0);
      chk("status", {20'h0, fe[3], fe[2], fe[1], fe[0]}, rd);
      @(posedge clk_i);
      pwm <= 3'($urandom);
      dpw <= 1'($urandom);
      @(negedge clk_i);
      ps = pin_in;
      @(posedge clk_i);
      #1;
      for (int i = 0; i < 4; i++) begin
        chk("capture", (fe[i] == tps_pkg::FN_CAP) ? 32'(ps[i]) : 32'h0, 32'(cap[i]));
        // a compare pin drives unless its channel is handed to pin a or b
        oe_e = (fe[i] == tps_pkg::FN_CMP) ? (i < 2 || cat[4 * i + 3]) : (fe[i] > tps_pkg::FN_TRIG);
        chk("oe", 32'(oe_e), 32'(pin_oe[i]));
        if (fe[i] == tps_pkg::FN_PWM) chk("pwm out", 32'(pwm[i - 1]), 32'(pin_out[i]));
        if (fe[i] == tps_pkg::FN_DPWM) chk("dpwm out", 32'(dpw), 32'(pin_out[i]));
      end
      chk("trigger", (fe[0] == tps_pkg::FN_TRIG) ? 32'(ps[0]) : 32'h0, 32'(trig));
      chk("buffer en", 32'(md[4:3]), 32'(bufe));
    end
    $display("test random done");
    // reroute: buffers off, both output selects cleared, a low c high, b high d low
    wb(1'b1, 8'h00, 32'h0);
    wb(1'b1, 8'h04, 32'h20);
    wb(1'b1, 8'h08, 32'h21);
    wb(1'b1, 8'h0C, 32'h12);
    // matches of a paired channel come in separate cycles, as distinct values give
    for (int k = 0; k < 6; k++) begin
      @(posedge clk_i);
      cmp <= rr_m[k];
      @(posedge clk_i);
      cmp <= 4'h0;
      #1;
      chk("reroute out", 32'(rr_e[k]), 32'(pin_out[1:0]));
      chk("reroute oe", 32'h3, 32'(pin_oe));
    end
    $display("test reroute done");
    // output selects back to 1: c goes high, d toggles, a and b keep their levels
    wb(1'b1, 8'h0C, 32'hBA);
    @(posedge clk_i);
    cmp <= 4'hC;
    @(posedge clk_i);
    cmp <= 4'h0;
    #1;
    chk("direct out", 32'hF, 32'(pin_out));
    chk("direct oe", 32'hF, 32'(pin_oe));
    $display("test direct done");
    tally_and_finish();
  end
endmodule
`default_nettype wire

// ### sim/tps_pin_partner.sv
// model of the circuitry hanging on the four timer pins
// assumes oe high means the block drives that pin
`timescale 1ns/1ps
`default_nettype none
module tps_pin_partner (
  input  wire logic       clk_i,
  input  wire logic [3:0] pin_out_i,
  input  wire logic [3:0] pin_oe_i,
  output logic      [3:0] pin_in_o
);
  logic [3:0] pat_r = 4'h1;
  // released pins follow a twisted-ring pattern, one pin changing each cycle, so a level one cycle stale differs from a fresh read on that one pin only
  always_ff @(posedge clk_i) begin
    pat_r <= {pat_r[2:0], ~pat_r[3]};
  end
  // driven pins read back what the block drives
  assign pin_in_o = (pin_oe_i & pin_out_i) | (~pin_oe_i & pat_r);
endmodule
`default_nettype wire
